// [logic/dmahm_pkg.sv]
// package for the dma-to-host address mapper
// assumes one 40 MHz clock and an avalon-mm register slave
package dmahm_pkg;
  // ----------------------------------------------------------------
  // table geometry
  // ----------------------------------------------------------------
  localparam int          ENTRIES    = 4096;
  localparam int          IDX_W      = 12;
  localparam int          PAGE_W     = 12;
  localparam int          LADDR_W    = 24;
  localparam int          UPPER_W    = 20;
  localparam int          AV_ADDR_W  = 17;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [16:0] SEG2_BASE  = 17'h08000;
  localparam logic [16:0] MAP_BASE   = 17'h0c000;
  localparam logic [16:0] MAP_LAST   = 17'h0fffc;
  localparam logic [16:0] REG_DADDR  = 17'h10000;
  localparam logic [16:0] REG_CTRL   = 17'h10004;
  localparam logic [16:0] REG_STAT   = 17'h10008;
  localparam logic [16:0] REG_ISTAT  = 17'h1000c;
  localparam logic [16:0] REG_IMASK  = 17'h10010;
  localparam logic [16:0] REG_CADDR  = 17'h10014;
  // ----------------------------------------------------------------
  // entry fields
  // ----------------------------------------------------------------
  localparam int          ENT_INV    = 0;
  localparam int          ENT_BSWAP  = 1;
  localparam int          ENT_WSWAP  = 2;
  localparam int          ENT_UP_LSB = 12;
  localparam int          ADDR_A1    = 1;
  // ----------------------------------------------------------------
  // control, status and interrupt bits
  // ----------------------------------------------------------------
  localparam int          CTRL_START = 0;
  localparam int          CTRL_STOP  = 1;
  localparam int          STAT_ACT   = 0;
  localparam int          STAT_FAULT = 1;
  localparam int          IRQ_W      = 3;
  localparam int          IRQ_FAULT  = 0;
  localparam int          IRQ_CROSS  = 1;
  localparam int          IRQ_DONE   = 2;
  // ----------------------------------------------------------------
  // transfer sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'h0,
    SZ_WORD  = 2'h1,
    SZ_DWORD = 2'h2
  } dmahm_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN  = 2'h2
  } dmahm_state_t;

  // bytes moved by one beat of the given size
  function automatic logic [LADDR_W-1:0] beat_bytes(input logic [1:0] s);
    beat_bytes = (s == SZ_DWORD) ? 24'h000004 :
                 (s == SZ_WORD)  ? 24'h000002 : 24'h000001;
  endfunction : beat_bytes
endpackage : dmahm_pkg

// [logic/dmahm_xlate.sv]
// translates one dma beat through a mapping entry
// assumes entry and beat come from the same clock; purely combinational
`timescale 1ns/10ps
module dmahm_xlate
  import dmahm_pkg::*;
(
  input  wire logic [31:0]          entry,
  input  wire logic                 entry_ok,
  input  wire logic [LADDR_W-1:0]   laddr,
  input  wire logic [1:0]           size,
  input  wire logic [31:0]          wdata,
  output logic      [31:0]          haddr,
  output logic      [31:0]          hdata,
  output logic                      usable
);
  // ----------------------------------------------------------------
  // address forming
  // ----------------------------------------------------------------
  wire logic [PAGE_W-1:0] low_addr = laddr[PAGE_W-1:0];
  wire logic              flip_a1  = entry[ENT_WSWAP];
  // upper bits from the entry, low bits from the dma address
  assign haddr = {entry[31:ENT_UP_LSB],
                  low_addr[PAGE_W-1:ADDR_A1+1],
                  low_addr[ADDR_A1] ^ flip_a1,
                  low_addr[0]};
  // reserved bits 3..11 are not looked at anywhere
  assign usable = entry_ok & ~entry[ENT_INV];
  // ----------------------------------------------------------------
  // byte swapping on non-byte data
  // ----------------------------------------------------------------
  wire logic [31:0] sw_word  = {wdata[23:16], wdata[31:24],
                                wdata[7:0],   wdata[15:8]};
  wire logic [31:0] sw_dword = {wdata[7:0],   wdata[15:8],
                                wdata[23:16], wdata[31:24]};
  wire logic        do_swap  = entry[ENT_BSWAP];
  assign hdata = (!do_swap || size == SZ_BYTE) ? wdata :
                 (size == SZ_WORD) ? sw_word : sw_dword;
endmodule : dmahm_xlate

// [logic/dmahm_mapper.sv]
// dma-to-host address mapper: page table, translation, busy fencing
// assumes avalon-mm master on core_clk; dma controller on same clock
`timescale 1ns/10ps
module dmahm_mapper
  import dmahm_pkg::*;
#(
  parameter int N_ENT = ENTRIES
)(
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic [dmahm_pkg::AV_ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       xfer_req,
  input  wire logic [1:0]                 xfer_size,
  input  wire logic [31:0]                xfer_data,
  input  wire logic                       dma_done,
  output logic                            dma_run,
  output logic                            host_req,
  output logic      [31:0]                host_addr,
  output logic      [31:0]                host_data,
  output logic      [1:0]                 host_size,
  output logic                            host_timeout,
  output logic                            remote_allow,
  output logic                            irq_pass_en,
  output logic                            irq
);
  import dmahm_pkg::*;

  // ----------------------------------------------------------------
  // storage and registers
  // ----------------------------------------------------------------
  logic [31:0]         table_q [N_ENT];  // no reset: storage
  logic [N_ENT-1:0]    written_q;
  logic [LADDR_W-1:0]  daddr_q;
  logic [LADDR_W-1:0]  caddr_q;
  logic [IRQ_W-1:0]    istat_q;
  logic [IRQ_W-1:0]    imask_q;
  logic                fault_q;
  dmahm_state_t        state_q;
  logic                wait_q;
  logic [31:0]         rdata_q;
  logic                host_req_q;
  logic [31:0]         host_addr_q;
  logic [31:0]         host_data_q;
  logic [1:0]          host_size_q;
  logic                host_to_q;
  logic                run_q;
  logic                allow_q;
  logic                pass_q;
  logic                irq_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic       req     = avs_read | avs_write;
  wire logic       commit  = req & ~wait_q;
  wire logic       wr_go   = avs_write & commit;
  wire logic       in_map  = avs_address >= MAP_BASE &&
                             avs_address <= MAP_LAST;
  wire logic [IDX_W-1:0] bus_idx = avs_address[IDX_W+1:2];
  wire logic       wr_map  = wr_go & in_map;
  wire logic       wr_daddr = wr_go & (avs_address == REG_DADDR);
  wire logic       wr_ctrl  = wr_go & (avs_address == REG_CTRL);
  wire logic       wr_istat = wr_go & (avs_address == REG_ISTAT);
  wire logic       wr_imask = wr_go & (avs_address == REG_IMASK);
  wire logic       running  = (state_q == ST_RUN);
  wire logic       go_start = wr_ctrl & avs_writedata[CTRL_START]
                              & avs_byteenable[0] & ~running;
  wire logic       go_stop  = running &
                     (dma_done | (wr_ctrl & avs_writedata[CTRL_STOP]
                                  & avs_byteenable[0]));

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // dma start address with the write's lanes merged in
  wire logic [31:0] daddr_mrg =
    merge({8'h00, daddr_q}, avs_writedata, avs_byteenable);

  // ----------------------------------------------------------------
  // read mux; other segments and holes read as zero
  // ----------------------------------------------------------------
  wire logic [31:0] map_word = table_q[bus_idx];
  wire logic [31:0] rd_mux =
    in_map                     ? map_word :
    avs_address == REG_DADDR   ? {8'h00, daddr_q} :
    avs_address == REG_STAT    ? {30'h0, fault_q, running} :
    avs_address == REG_ISTAT   ? {29'h0, istat_q} :
    avs_address == REG_IMASK   ? {29'h0, imask_q} :
    avs_address == REG_CADDR   ? {8'h00, caddr_q} : 32'h0;

  // ----------------------------------------------------------------
  // translation of the current beat
  // ----------------------------------------------------------------
  wire logic [IDX_W-1:0] cur_idx = caddr_q[LADDR_W-1:PAGE_W];
  wire logic [31:0]      cur_ent = table_q[cur_idx];
  wire logic [31:0]      x_addr;
  wire logic [31:0]      x_data;
  wire logic             x_ok;
  wire logic             beat    = running & xfer_req;
  wire logic [LADDR_W-1:0] next_caddr =
    caddr_q + beat_bytes(xfer_size);
  wire logic             crosses =
    beat & (next_caddr[LADDR_W-1:PAGE_W] != cur_idx);

  dmahm_xlate u_xlate (
    .entry    (cur_ent),
    .entry_ok (written_q[cur_idx]),
    .laddr    (caddr_q),
    .size     (xfer_size),
    .wdata    (xfer_data),
    .haddr    (x_addr),
    .hdata    (x_data),
    .usable   (x_ok)
  );

  wire logic [IRQ_W-1:0] ev = {go_stop, crosses, beat & ~x_ok};

  // ----------------------------------------------------------------
  // mapping table writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (ce && wr_map) begin
      table_q[bus_idx] <= merge(map_word, avs_writedata,
                                avs_byteenable);
    end
  end

  // entries count as invalid until written once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      written_q <= '0;
    end else if (ce && wr_map) begin
      written_q[bus_idx] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else if (ce) begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // software registers and sticky interrupt status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      daddr_q <= '0;
      imask_q <= '0;
      istat_q <= '0;
    end else if (ce) begin
      if (wr_daddr) begin
        daddr_q <= daddr_mrg[LADDR_W-1:0];
      end
      if (wr_imask) begin
        imask_q <= avs_writedata[IRQ_W-1:0];
      end
      // set wins over a clear in the same cycle
      istat_q <= (istat_q & ~({IRQ_W{wr_istat}} &
                              avs_writedata[IRQ_W-1:0])) | ev;
    end
  end

  // ----------------------------------------------------------------
  // dma run state and address walk
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      caddr_q <= '0;
      fault_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          if (go_start) begin
            state_q <= ST_RUN;
            caddr_q <= daddr_q;
            fault_q <= 1'b0;
          end
        end
        ST_RUN: begin
          if (go_stop) begin
            state_q <= ST_IDLE;
          end
          if (beat) begin
            caddr_q <= next_caddr;
            fault_q <= fault_q | ~x_ok;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // host side beat and fencing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_req_q  <= 1'b0;
      host_to_q   <= 1'b0;
      host_addr_q <= 32'h0;
      host_data_q <= 32'h0;
      host_size_q <= SZ_BYTE;
      run_q       <= 1'b0;
      allow_q     <= 1'b1;
      pass_q      <= 1'b1;
      irq_q       <= 1'b0;
    end else if (ce) begin
      host_req_q  <= beat & x_ok;
      host_to_q   <= beat & ~x_ok;
      if (beat) begin
        host_addr_q <= x_addr;
        host_data_q <= x_data;
        host_size_q <= xfer_size;
      end
      run_q   <= (running & ~go_stop) | go_start;
      allow_q <= ~((running & ~go_stop) | go_start);
      pass_q  <= ~((running & ~go_stop) | go_start);
      irq_q   <= |((istat_q | ev) & imask_q);
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign dma_run         = run_q;
  assign host_req        = host_req_q;
  assign host_addr       = host_addr_q;
  assign host_data       = host_data_q;
  assign host_size       = host_size_q;
  assign host_timeout    = host_to_q;
  assign remote_allow    = allow_q;
  assign irq_pass_en     = pass_q;
  assign irq             = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fence_remote: assert property (@(posedge core_clk) disable iff (rst)
    (ce && running && !go_stop) |=> (dma_run && !remote_allow))
    else $error("remote access allowed during dma");
  a_fence_irq: assert property (@(posedge core_clk) disable iff (rst)
    (ce && running && !go_stop) |=> (dma_run && !irq_pass_en))
    else $error("interrupt passing during dma");
  a_invalid_blocks: assert property (@(posedge core_clk) disable iff (rst)
    (ce && beat && cur_ent[ENT_INV]) |=> (host_timeout && !host_req))
    else $error("beat through invalid entry not refused");
  a_addr_low: assert property (@(posedge core_clk) disable iff (rst)
    (ce && beat && x_ok) |=> host_addr[PAGE_W-1:2] ==
      $past(caddr_q[PAGE_W-1:2]))
    else $error("low host address bits wrong");
  a_addr_up: assert property (@(posedge core_clk) disable iff (rst)
    (ce && beat && x_ok) |=> host_addr[31:ENT_UP_LSB] ==
      $past(cur_ent[31:ENT_UP_LSB]))
    else $error("upper host address bits wrong");
  a_a1_flip: assert property (@(posedge core_clk) disable iff (rst)
    (ce && beat && x_ok) |=> host_addr[ADDR_A1] ==
      ($past(caddr_q[ADDR_A1]) ^ $past(cur_ent[ENT_WSWAP])))
    else $error("a1 inversion wrong");
  a_byte_keep: assert property (@(posedge core_clk) disable iff (rst)
    (ce && beat && x_ok && xfer_size == SZ_BYTE) |=>
      host_data == $past(xfer_data))
    else $error("byte beat altered");
  a_page_step: assert property (@(posedge core_clk) disable iff (rst)
    (ce && beat && !go_stop) |=> caddr_q ==
      $past(caddr_q) + beat_bytes($past(xfer_size)))
    else $error("dma address walk wrong");
  a_map_write: assert property (@(posedge core_clk) disable iff (rst)
    (ce && wr_map && avs_byteenable == 4'hf) |=>
      table_q[$past(bus_idx)] == $past(avs_writedata))
    else $error("entry write lost");
endmodule : dmahm_mapper

// [sim/dmahm_host_mem.sv]
// host memory model behind the mapper's host-side beat outputs
// assumes one-cycle host_req or host_timeout pulses on core_clk
`timescale 1ns/10ps
module dmahm_host_mem (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        host_req,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_data,
  input wire logic [1:0]  host_size,
  input wire logic        host_timeout
);
  logic [66:0] log_q[$];              // beats seen, oldest first
  logic [31:0] store[logic [31:0]];   // host memory contents
  // take each beat while its pulse stands; a refused beat stores nothing
  always @(posedge core_clk) begin
    if (rst) begin
      log_q.delete();
    end else if (host_timeout === 1'b1) begin
      log_q.push_back({1'b1, 66'h0});
    end else if (host_req === 1'b1) begin
      store[host_addr] = host_data;
      log_q.push_back({1'b0, host_size, host_addr, host_data});
    end
  end
endmodule : dmahm_host_mem

// [sim/dmahm_mapper_bench.sv]
// self-checking bench for the dma-to-host address mapper
// assumes 40 MHz core_clk; bench plays avalon master and dma controller
`timescale 1ns/10ps
module dmahm_mapper_bench;
  import dmahm_pkg::*;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [AV_ADDR_W-1:0] avs_address = '0;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [31:0]          avs_writedata = '0;
  logic [3:0]           avs_byteenable = 4'hf;
  logic                 xfer_req = 1'b0;
  logic [1:0]           xfer_size = 2'h0;
  logic [31:0]          xfer_data = '0;
  logic                 dma_done = 1'b0;
  logic [31:0]          avs_readdata, host_addr, host_data, rd_s, q, v;
  logic                 avs_waitrequest, dma_run, host_req, host_timeout;
  logic                 remote_allow, irq_pass_en, irq;
  logic [1:0]           host_size;
  logic [4:0]           o_s;          // waitreq, run, remote, irq pass, irq
  logic [31:0]          shadow[int];  // what software wrote to the table
  logic [66:0]          exp_q[$];
  int                   err_count = 0;
  int                   n_checks = 0;
  int                   seed = 15;
  int                   p;

  always #12.5 core_clk = ~core_clk;
  // outputs are read at the falling edge, settled before the next rise
  always @(negedge core_clk) begin
    o_s = {avs_waitrequest, dma_run, remote_allow, irq_pass_en, irq};
    rd_s = avs_readdata;
  end

  dmahm_mapper dut (
    .core_clk(core_clk), .rst(rst), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .xfer_req(xfer_req),
    .xfer_size(xfer_size), .xfer_data(xfer_data), .dma_done(dma_done),
    .dma_run(dma_run), .host_req(host_req), .host_addr(host_addr),
    .host_data(host_data), .host_size(host_size),
    .host_timeout(host_timeout), .remote_allow(remote_allow),
    .irq_pass_en(irq_pass_en), .irq(irq)
  );
  dmahm_host_mem mem (
    .core_clk(core_clk), .rst(rst), .host_req(host_req),
    .host_addr(host_addr), .host_data(host_data),
    .host_size(host_size), .host_timeout(host_timeout)
  );

  // ----------------------------------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [66:0] seen, input logic [66:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one avalon cycle, entered just after a rising edge
  task automatic bus(input logic wr_en, input logic [16:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rq);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (o_s[4] !== 1'b0 && n < 40);
    rq = rd_s;
    if (n >= 40) err_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    logic [31:0] dq;
    bus(1'b1, a, d, 4'hf, dq);
  endtask : wr

  task automatic rd(input logic [16:0] a, output logic [31:0] rq);
    bus(1'b0, a, 32'h0, 4'hf, rq);
  endtask : rd

  // expected host beat for one dma beat through entry e
  function automatic logic [66:0] xp(input logic [31:0] e,
      input logic [23:0] la, input logic [1:0] s, input logic [31:0] d);
    logic [31:0] x;
    x = d;
    if (e[1] && s == SZ_WORD) x = {d[23:16], d[31:24], d[7:0], d[15:8]};
    if (e[1] && s == SZ_DWORD) x = {d[7:0], d[15:8], d[23:16], d[31:24]};
    if (e[0] !== 1'b0) return {1'b1, 66'h0};   // refused beat
    return {1'b0, s, e[31:12], la[11:2], la[1] ^ e[2], la[0], x};
  endfunction : xp

  // one dma run of nb random beats from start, irq mask m
  task automatic run_dma(input logic [23:0] start, input int nb,
                         input logic [2:0] m);
    logic [23:0] la;
    logic [1:0]  s;
    logic [31:0] d, e, rq;
    logic        flt;
    logic [2:0]  xev;
    int          n;
    la = start;
    flt = 1'b0;
    n = 0;
    wr(REG_IMASK, {29'h0, m});
    wr(REG_DADDR, {8'h0, start});
    wr(REG_CTRL, 32'h1);
    while (o_s[3] !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    for (int i = 0; i < nb; i++) begin
      s = 2'($unsigned($random(seed)) % 3);
      d = $random(seed);
      e = shadow.exists(int'(la[23:12])) ? shadow[int'(la[23:12])] : 32'h1;
      exp_q.push_back(xp(e, la, s, d));
      flt |= e[0];
      xfer_req <= 1'b1;
      xfer_size <= s;
      xfer_data <= d;
      @(posedge core_clk);
      la = la + ((s == SZ_DWORD) ? 24'h4 : (s == SZ_WORD) ? 24'h2 : 24'h1);
    end
    xfer_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(67'(o_s[2:1]), 67'h0);
    rd(REG_CADDR, rq);
    check(67'(rq), 67'(la));
    if (start[23:12] == 12'd1800) begin
      wr(REG_CTRL, 32'h2);                            // stop by software
    end else begin
      dma_done <= 1'b1;
      @(posedge core_clk);
      dma_done <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
    check(67'(o_s[3:1]), 67'h3);
    rd(REG_STAT, rq);
    check(67'(rq), 67'({flt, 1'b0}));
    check(67'(mem.log_q.size()), 67'(exp_q.size()));
    while (exp_q.size() > 0 && mem.log_q.size() > 0)
      check(mem.log_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    rd(REG_ISTAT, rq);
    xev = {1'b1, la[23:12] != start[23:12], flt};
    check(67'(rq), 67'(xev));
    check(67'(o_s[0]), 67'(|(xev & m)));
    wr(REG_ISTAT, 32'h7);
    rd(REG_ISTAT, rq);
    check(67'({rq, o_s[0]}), 67'h0);
  endtask : run_dma

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    check(67'(o_s), 67'h16);
    rst <= 1'b0;
    @(posedge core_clk);
    $display("test reset done");
    // table fill at both ends and random places, read back
    for (int k = 0; k < 8; k++) begin
      p = (k == 0) ? 0 : (k == 1) ? ENTRIES - 1 : $unsigned($random(seed)) % ENTRIES;
      v = $random(seed);
      wr(MAP_BASE + 17'(4 * p), v);
      shadow[p] = v;
    end
    foreach (shadow[i]) begin
      rd(MAP_BASE + 17'(4 * i), q);
      check(67'(q), 67'(shadow[i]));
    end
    bus(1'b1, MAP_BASE, 32'hffffffff, 4'h1, q);
    shadow[0] = {shadow[0][31:8], 8'hff};
    rd(MAP_BASE, q);
    check(67'(q), 67'(shadow[0]));
    rd(SEG2_BASE, q);
    check(67'(q), 67'h0);
    $display("test table done");
    // runs crossing a page; run 2 meets an invalid next page
    for (int k = 1; k <= 4; k++) begin
      p = 600 * k;
      for (int j = 0; j < 2; j++) begin
        v = $random(seed);
        v[0] = (k == 2 && j == 1);
        if (k == 4) v[11:3] = 9'h1ff;
        wr(MAP_BASE + 17'(4 * (p + j)), v);
        shadow[p + j] = v;
      end
      run_dma({12'(p), 12'hff0 + 12'($unsigned($random(seed)) % 16)}, 20,
              3'($random(seed)) & 3'h5);
      $display("test run %0d done", k);
    end
    run_dma({12'd4000, 12'h010}, 3, 3'h1);
    $display("test unwritten page done");
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
endmodule : dmahm_mapper_bench
